/* File: verilog/fbo_host.sv */
// Host-side controller driving the parallel flash bus pins
`timescale 1ns/1ps
`default_nettype none
module fbo_host (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// User command port
	input  wire logic                      req_valid,
	output logic                           req_ready,
	input  wire logic                      req_write,
	input  wire logic                      req_byte_mode,
	input  wire logic [fbo_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [fbo_pkg::DATA_W-1:0] req_wdata,
	input  wire logic                      req_flash_reset,
	output logic                           rsp_valid,
	output logic [fbo_pkg::DATA_W-1:0]     rsp_rdata,
	output logic                           dev_busy,
	// Flash pins
	output logic                           chip_select_n,
	output logic                           output_enable_n,
	output logic                           write_enable_n,
	output logic                           width_select_n,
	output logic                           hw_reset_n,
	output logic [fbo_pkg::ADDR_W-1:0]     flash_addr,
	input  wire logic [fbo_pkg::DATA_W-1:0] dq_i,
	output logic [fbo_pkg::DATA_W-1:0]     dq_o,
	output logic                           dq_oe,
	input  wire logic                      ready_busy_n
);
	import fbo_pkg::*;

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction : cyc

	// ----------------------------------------
	// Bus sequencer
	// ----------------------------------------
	fbo_state_t             st_r,    st_nxt;
	logic [CNT_W-1:0]       cnt_r,   cnt_nxt;
	logic                   cs_r,    cs_nxt;
	logic                   oe_r,    oe_nxt;
	logic                   we_r,    we_nxt;
	logic                   byte_r,  byte_nxt;
	logic                   rstp_r,  rstp_nxt;
	logic [ADDR_W-1:0]      addr_r,  addr_nxt;
	logic [DATA_W-1:0]      wd_r,    wd_nxt;
	logic                   drv_r,   drv_nxt;
	logic [DATA_W-1:0]      rd_r,    rd_nxt;
	logic                   rv_r,    rv_nxt;

	always_comb begin
		st_nxt   = st_r;
		cnt_nxt  = cnt_r;
		cs_nxt   = cs_r;
		oe_nxt   = oe_r;
		we_nxt   = we_r;
		byte_nxt = byte_r;
		rstp_nxt = rstp_r;
		addr_nxt = addr_r;
		wd_nxt   = wd_r;
		drv_nxt  = drv_r;
		rd_nxt   = rd_r;
		rv_nxt   = 1'b0;
		case (st_r)
			FBO_IDLE: begin
				if (req_valid && req_flash_reset) begin
					rstp_nxt = 1'b0;
					cs_nxt   = 1'b1;
					oe_nxt   = 1'b1;
					we_nxt   = 1'b1;
					drv_nxt  = 1'b0;
					cnt_nxt  = cyc(RESET_PULSE_CYC);
					st_nxt   = FBO_RST;
				end else if (req_valid && req_write) begin
					byte_nxt = !req_byte_mode;
					addr_nxt = req_addr;
					wd_nxt   = req_wdata;
					cs_nxt   = 1'b0;
					oe_nxt   = 1'b1;
					we_nxt   = 1'b0;
					drv_nxt  = 1'b1;
					cnt_nxt  = cyc(WRITE_PULSE_CYC);
					st_nxt   = FBO_WR;
				end else if (req_valid) begin
					// Read cycle, wait full select access
					byte_nxt = !req_byte_mode;
					addr_nxt = req_addr;
					cs_nxt   = 1'b0;
					oe_nxt   = 1'b0;
					we_nxt   = 1'b1;
					drv_nxt  = 1'b0;
					cnt_nxt  = cyc(SELECT_ACCESS_CYC > ADDR_ACCESS_CYC ? SELECT_ACCESS_CYC : ADDR_ACCESS_CYC);
					st_nxt   = FBO_RD;
				end
			end
			FBO_RD: begin
				if (cnt_r == CNT_ZERO) begin
					// Byte mode keeps low byte only
					rd_nxt  = byte_r ? dq_i : {8'h00, dq_i[7:0]};
					rv_nxt  = 1'b1;
					cs_nxt  = 1'b1;
					oe_nxt  = 1'b1;
					st_nxt  = FBO_IDLE;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			FBO_WR: begin
				if (cnt_r == CNT_ZERO) begin
					// Rising edge latches data; hold after
					we_nxt  = 1'b1;
					cs_nxt  = 1'b1;
					cnt_nxt = cyc(WRITE_HOLD_CYC);
					st_nxt  = FBO_WHOLD;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			FBO_WHOLD: begin
				if (cnt_r == CNT_ZERO) begin
					drv_nxt = 1'b0;
					rv_nxt  = 1'b1;
					st_nxt  = FBO_IDLE;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			FBO_RST: begin
				if (cnt_r == CNT_ZERO) begin
					rstp_nxt = 1'b1;
					cnt_nxt  = cyc(POST_RESET_CYC);
					st_nxt   = FBO_RREC;
				end else begin
					cnt_nxt = cnt_r - 8'h01;
				end
			end
			FBO_RREC: begin
				// Wait for device ready after reset
				if (cnt_r != CNT_ZERO) begin
					cnt_nxt = cnt_r - 8'h01;
				end else if (ready_busy_n) begin
					rv_nxt = 1'b1;
					st_nxt = FBO_IDLE;
				end
			end
			default: begin
				st_nxt = FBO_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			st_r   <= FBO_IDLE;
			cnt_r  <= CNT_ZERO;
			cs_r   <= 1'b1;
			oe_r   <= 1'b1;
			we_r   <= 1'b1;
			byte_r <= 1'b1;
			rstp_r <= 1'b1;
			addr_r <= ADDR_ZERO;
			wd_r   <= DATA_ZERO;
			drv_r  <= 1'b0;
			rd_r   <= DATA_ZERO;
			rv_r   <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			cnt_r  <= cnt_nxt;
			cs_r   <= cs_nxt;
			oe_r   <= oe_nxt;
			we_r   <= we_nxt;
			byte_r <= byte_nxt;
			rstp_r <= rstp_nxt;
			addr_r <= addr_nxt;
			wd_r   <= wd_nxt;
			drv_r  <= drv_nxt;
			rd_r   <= rd_nxt;
			rv_r   <= rv_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign req_ready       = (st_r == FBO_IDLE);
	assign rsp_valid       = rv_r;
	assign rsp_rdata       = rd_r;
	// Busy shown so user holds writes; status reads still allowed
	assign dev_busy        = !ready_busy_n;
	assign chip_select_n   = cs_r;
	assign output_enable_n = oe_r;
	assign write_enable_n  = we_r;
	assign width_select_n  = byte_r;
	assign hw_reset_n      = rstp_r;
	assign flash_addr      = addr_r;
	// Byte mode drives zero on the upper byte
	assign dq_o            = byte_r ? wd_r : {8'h00, wd_r[7:0]};
	// Never drive while output enable low
	assign dq_oe           = drv_r && oe_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_no_contention;
		@(posedge clk) disable iff (!rst_s2_r) !(dq_oe && !output_enable_n);
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("host drives dq with oe low");

	property p_read_levels;
		@(posedge clk) disable iff (!rst_s2_r) (st_r == FBO_RD) |-> (!chip_select_n && !output_enable_n && write_enable_n);
	endproperty
	a_read_levels: assert property (p_read_levels) else $error("bad read levels");

	property p_write_levels;
		@(posedge clk) disable iff (!rst_s2_r) (st_r == FBO_WR) |-> (!chip_select_n && output_enable_n && !write_enable_n && dq_oe);
	endproperty
	a_write_levels: assert property (p_write_levels) else $error("bad write levels");

	property p_read_access;
		@(posedge clk) disable iff (!rst_s2_r) $fell(chip_select_n) && write_enable_n |-> !chip_select_n [*8];
	endproperty
	a_read_access: assert property (p_read_access) else $error("select access too short");

	property p_reset_pulse;
		@(posedge clk) disable iff (!rst_s2_r) $fell(hw_reset_n) |-> !hw_reset_n [*8] ##0 (st_r == FBO_RST);
	endproperty
	a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too short");

	property p_reset_quiet;
		@(posedge clk) disable iff (!rst_s2_r) !hw_reset_n |-> (chip_select_n && write_enable_n && !dq_oe);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("access during reset");

	property p_recovery;
		@(posedge clk) disable iff (!rst_s2_r) $rose(hw_reset_n) |-> chip_select_n [*7];
	endproperty
	a_recovery: assert property (p_recovery) else $error("access before recovery");

	property p_byte_read;
		@(posedge clk) disable iff (!rst_s2_r) rsp_valid && !width_select_n && ($past(st_r) == FBO_RD) |-> rsp_rdata[15:8] == 8'h00;
	endproperty
	a_byte_read: assert property (p_byte_read) else $error("byte read upper not zero");

	c_read:  cover property (@(posedge clk) disable iff (!rst_s2_r) st_r == FBO_RD ##[1:20] rsp_valid);
	c_write: cover property (@(posedge clk) disable iff (!rst_s2_r) st_r == FBO_WHOLD ##[1:10] st_r == FBO_IDLE);
	c_reset: cover property (@(posedge clk) disable iff (!rst_s2_r) st_r == FBO_RREC ##[1:100] st_r == FBO_IDLE);
endmodule : fbo_host
`default_nettype wire

/* File: verilog/fbo_pkg.sv */
// Package: constants and types for the flash bus host controller
`default_nettype none
package fbo_pkg;
	localparam int          CLK_PERIOD_NS      = 8;
	localparam int          ADDR_W             = 19;
	localparam int          DATA_W             = 16;
	// Access and reset intervals in ns, plain defaults
	localparam int          SELECT_ACCESS_NS   = 70;
	localparam int          ADDR_ACCESS_NS     = 70;
	localparam int          MIN_RESET_PULSE_NS = 500;
	localparam int          POST_RESET_REC_NS  = 50;
	localparam int          READY_IDLE_NS      = 500;
	localparam int          WRITE_PULSE_NS     = 35;
	localparam int          WRITE_HOLD_NS      = 20;
	// Cycle counts, least times rounded up
	localparam int          SELECT_ACCESS_CYC  = (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ADDR_ACCESS_CYC    = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          RESET_PULSE_CYC    = (MIN_RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          POST_RESET_CYC     = (POST_RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          READY_IDLE_CYC     = (READY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WRITE_PULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          WRITE_HOLD_CYC     = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W              = 8;
	localparam logic [7:0]  CNT_ZERO           = 8'h00;
	localparam logic [15:0] DATA_ZERO          = 16'h0000;
	localparam logic [18:0] ADDR_ZERO          = 19'h00000;

	typedef enum logic [2:0] {
		FBO_IDLE   = 3'b000,
		FBO_RD     = 3'b001,
		FBO_WR     = 3'b010,
		FBO_WHOLD  = 3'b011,
		FBO_RST    = 3'b100,
		FBO_RREC   = 3'b101
	} fbo_state_t;
endpackage : fbo_pkg
`default_nettype wire

/* File: testbench/fbo_flash_model.sv */
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
`default_nettype none
module fbo_flash_model #(
	parameter logic [7:0] STAT     = 8'h4c,
	// Identification code and command codes: arbitrary values
	parameter logic [7:0] ID_CODE  = 8'h5a,
	parameter logic [7:0] ID_CMD   = 8'h6d,
	parameter logic [7:0] EXIT_CMD = 8'h6e,
	parameter int         ACC_CYC  = 9,
	parameter int         BUSY_CYC = 40
) (
	// Clock for the model's counters
	input  wire logic        clk,
	// Device pins
	input  wire logic        chip_select_n,
	input  wire logic        output_enable_n,
	input  wire logic        write_enable_n,
	input  wire logic        width_select_n,
	input  wire logic        hw_reset_n,
	input  wire logic [18:0] flash_addr,
	input  wire logic [15:0] dq_o,
	input  wire logic        dq_oe,
	output logic      [15:0] dq_i,
	output logic             ready_busy_n
);
	logic [15:0] mem [16];
	logic [15:0] flt_r  = 16'h0000;
	logic [15:0] wd_r   = 16'h0000;
	logic [15:0] pd_r   = 16'h0000;
	logic [3:0]  wa_r   = 4'h0;
	logic [3:0]  pa_r   = 4'h0;
	logic        wr_r   = 1'b0;
	logic        pend_r = 1'b0;
	logic        id_r   = 1'b0;
	int          busy_r = 0;
	int          sel_r  = 0;
	logic        drv;
	logic [15:0] rd;
	initial for (int i = 0; i < 16; i++) mem[i] = {4'ha, 4'(i), 4'h5, 4'(~i)};
	// no unlock, erase or high voltage; one write programs
	always @(posedge clk) begin
		// Undriven lines wander, never a stale value
		flt_r <= flt_r + 16'h3c5b;
		// data hidden until full select time
		if (chip_select_n || !hw_reset_n) sel_r <= 0;
		else if (sel_r < ACC_CYC) sel_r <= sel_r + 1;
		// reset aborts, busy held past reset
		if (!hw_reset_n) begin
			wr_r   <= 1'b0;
			pend_r <= 1'b0;
			id_r   <= 1'b0;
			if (busy_r > 0) busy_r <= 20;
		end else begin
			if (busy_r > 0) busy_r <= busy_r - 1;
			if (busy_r == 1 && pend_r) begin
				mem[pa_r] <= pd_r;
				pend_r    <= 1'b0;
			end
			// latch while low, commit on rising strobe
			if (!chip_select_n && !write_enable_n) begin
				wr_r <= 1'b1;
				wa_r <= flash_addr[3:0];
				wd_r <= dq_i;
			end else if (wr_r) begin
				wr_r <= 1'b0;
				if (wd_r[7:0] == ID_CMD) begin
					id_r <= 1'b1;
				end else if (wd_r[7:0] == EXIT_CMD) begin
					id_r <= 1'b0;
				end else begin
					// byte mode programs low byte only
					pa_r   <= wa_r;
					pd_r   <= width_select_n ? wd_r : {mem[wa_r][15:8], wd_r[7:0]};
					pend_r <= 1'b1;
					busy_r <= BUSY_CYC;
				end
			end
		end
	end
	// drive only on a read cycle
	assign drv = hw_reset_n && !chip_select_n && !output_enable_n && write_enable_n && (sel_r >= ACC_CYC);
	// array, status or code; sleep never shows
	assign rd = (busy_r > 0) ? {8'h00, STAT} : (id_r ? {8'h00, ID_CODE} : mem[flash_addr[3:0]]);
	assign ready_busy_n = (busy_r == 0);
	assign dq_i[7:0] = dq_oe ? dq_o[7:0] : (drv ? rd[7:0] : flt_r[7:0]);
	// upper byte floats in byte mode
	assign dq_i[15:8] = dq_oe ? dq_o[15:8] : ((drv && width_select_n) ? rd[15:8] : flt_r[15:8]);
endmodule : fbo_flash_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fbo_pkg::*;
	localparam logic [7:0] STAT = 8'h4c;
	// Identification code and command codes: arbitrary values
	localparam logic [7:0] ID_CODE  = 8'h5a;
	localparam logic [7:0] ID_CMD   = 8'h6d;
	localparam logic [7:0] EXIT_CMD = 8'h6e;
	logic clk, rst_n, req_valid, req_ready, req_write, req_byte_mode, req_flash_reset;
	logic rsp_valid, dev_busy, chip_select_n, output_enable_n, write_enable_n;
	logic width_select_n, hw_reset_n, dq_oe, ready_busy_n;
	logic [18:0] req_addr, flash_addr;
	logic [15:0] req_wdata, rsp_rdata, dq_i, dq_o, q, e;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	fbo_host uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
		.req_write(req_write), .req_byte_mode(req_byte_mode), .req_addr(req_addr), .req_wdata(req_wdata),
		.req_flash_reset(req_flash_reset), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_busy(dev_busy),
		.chip_select_n(chip_select_n), .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
		.width_select_n(width_select_n), .hw_reset_n(hw_reset_n), .flash_addr(flash_addr), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe(dq_oe), .ready_busy_n(ready_busy_n));
	fbo_flash_model #(.STAT(STAT), .ID_CODE(ID_CODE), .ID_CMD(ID_CMD), .EXIT_CMD(EXIT_CMD),
		.ACC_CYC(SELECT_ACCESS_CYC), .BUSY_CYC(40)) dev (.clk(clk), .chip_select_n(chip_select_n),
		.output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .width_select_n(width_select_n),
		.hw_reset_n(hw_reset_n), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
		.ready_busy_n(ready_busy_n));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [15:0] iv(input int i);
		return {4'ha, 4'(i), 4'h5, 4'(~i)};
	endfunction : iv
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : test_done
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		check_count++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	// One request, held until taken; bounded wait for the answer
	task automatic req(input logic w, input logic b, input logic f, input logic [18:0] a,
		input logic [15:0] d, output logic [15:0] r);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_write = w;
		req_byte_mode = b;
		req_flash_reset = f;
		req_addr = a;
		req_wdata = d;
		@(negedge clk);
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		@(negedge clk);
		while (rsp_valid !== 1'b1 && n < 400) begin
			n++;
			@(negedge clk);
		end
		r = rsp_rdata;
		chk({15'h0000, rsp_valid}, 16'h0001);
	endtask : req
	task automatic wait_ready;
		int n;
		n = 0;
		while (ready_busy_n !== 1'b1 && n < 200) begin
			n++;
			@(negedge clk);
		end
	endtask : wait_ready
	task automatic t_power;
		chk({15'h0000, chip_select_n}, 16'h0001);
		req(1'b0, 1'b0, 1'b0, 19'h00003, 16'h0000, q);
		chk(q, iv(3));
		$display("test power read done");
	endtask : t_power
	task automatic t_write;
		req(1'b1, 1'b0, 1'b0, 19'h00005, 16'hbeef, q);
		req(1'b0, 1'b0, 1'b0, 19'h00005, 16'h0000, q);
		chk(q, {8'h00, STAT});
		chk({15'h0000, dev_busy}, 16'h0001);
		wait_ready;
		req(1'b0, 1'b0, 1'b0, 19'h00005, 16'h0000, q);
		chk(q, 16'hbeef);
		$display("test write read done");
	endtask : t_write
	task automatic t_byte;
		req(1'b1, 1'b1, 1'b0, 19'h00006, 16'h12a5, q);
		wait_ready;
		req(1'b0, 1'b1, 1'b0, 19'h00006, 16'h0000, q);
		chk(q, 16'h00a5);
		e = iv(6);
		req(1'b0, 1'b0, 1'b0, 19'h00006, 16'h0000, q);
		chk(q, {e[15:8], 8'ha5});
		$display("test byte mode done");
	endtask : t_byte
	task automatic t_reset;
		req(1'b1, 1'b0, 1'b0, 19'h00007, 16'h5555, q);
		req(1'b0, 1'b0, 1'b1, 19'h00000, 16'h0000, q);
		chk({15'h0000, dev_busy}, 16'h0000);
		req(1'b0, 1'b0, 1'b0, 19'h00007, 16'h0000, q);
		chk(q, iv(7));
		req(1'b1, 1'b0, 1'b0, 19'h00007, 16'h5555, q);
		wait_ready;
		req(1'b0, 1'b0, 1'b1, 19'h00000, 16'h0000, q);
		req(1'b0, 1'b0, 1'b0, 19'h00002, 16'h0000, q);
		chk(q, iv(2));
		req(1'b0, 1'b0, 1'b0, 19'h00007, 16'h0000, q);
		chk(q, 16'h5555);
		$display("test reset done");
	endtask : t_reset
	task automatic t_ident;
		req(1'b1, 1'b0, 1'b0, 19'h00001, {8'h00, ID_CMD}, q);
		req(1'b0, 1'b0, 1'b0, 19'h00001, 16'h0000, q);
		chk(q, {8'h00, ID_CODE});
		req(1'b1, 1'b0, 1'b0, 19'h00001, {8'h00, EXIT_CMD}, q);
		req(1'b0, 1'b0, 1'b0, 19'h00001, 16'h0000, q);
		chk(q, iv(1));
		req(1'b1, 1'b0, 1'b0, 19'h00001, {8'h00, ID_CMD}, q);
		req(1'b0, 1'b0, 1'b1, 19'h00000, 16'h0000, q);
		req(1'b0, 1'b0, 1'b0, 19'h00001, 16'h0000, q);
		chk(q, iv(1));
		$display("test ident done");
	endtask : t_ident
	// Hang guard well above the several hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			test_done;
		end
	end
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_byte_mode = 1'b0;
		req_flash_reset = 1'b0;
		req_addr = 19'h00000;
		req_wdata = 16'h0000;
		repeat (16) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		t_power;
		t_write;
		t_byte;
		t_reset;
		t_ident;
		test_done;
	end
endmodule : tb_top
`default_nettype wire
